// ### rtl/uamr_pkg.sv
// package: shared types and constants for the modem, reset and serial framing block
`default_nettype none
package uamr_pkg;

  // configuration register image, loaded whole through the config port
  typedef struct packed {
    logic soft_rst_en;  // interrupt_enable_reg bit 5
    logic soft_rst;     // modem_control_reg bit 2
    logic loopback;
    logic tx_en;
    logic parity_en;
    logic parity_even;
    logic two_stop;
    logic rts;
    logic dtr;
  } uamr_cfg_t;

  typedef enum logic [2:0] {UAMR_TX_IDLE, UAMR_TX_START, UAMR_TX_DATA, UAMR_TX_PAR, UAMR_TX_STOP} uamr_tx_state_t;
  typedef enum logic [2:0] {UAMR_RX_IDLE, UAMR_RX_START, UAMR_RX_DATA, UAMR_RX_PAR, UAMR_RX_STOP} uamr_rx_state_t;

  // active-low modem inputs as seen at the pins
  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic cd_n;
    logic ri_n;
  } uamr_modem_in_t;

  // same lines, decoded active high
  typedef struct packed {
    logic cts;
    logic dsr;
    logic cd;
    logic ri;
  } uamr_modem_st_t;

  localparam uamr_cfg_t UAMR_CFG_RST = 9'h000;
  localparam logic [15:0] UAMR_OS_DIV_DEF = 16'h0044;  // 16x sample tick divider
  localparam logic [3:0] UAMR_PH_LAST = 4'hf;           // 16 samples per bit
  localparam logic [3:0] UAMR_PH_MID = 4'h7;            // start bit recheck point
  localparam logic [2:0] UAMR_BIT_LAST = 3'h7;          // eight data bits

endpackage : uamr_pkg
`default_nettype wire

// ### rtl/uamr_top.sv
// module: uart modem pins, reset output path and serial framer
`default_nettype none
module uamr_top #(
  parameter logic [15:0] OS_DIV = uamr_pkg::UAMR_OS_DIV_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cfg_wr,
  input wire uamr_pkg::uamr_cfg_t cfg_in,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_perr,
  output logic rx_ferr,
  input wire logic rxd,
  output logic txd,
  output logic rts_n,
  output logic dtr_n,
  input wire uamr_pkg::uamr_modem_in_t modem_in,
  output uamr_pkg::uamr_modem_st_t modem_st,
  output logic rst_out
);

  typedef struct packed {
    uamr_pkg::uamr_cfg_t cfg;
    logic [15:0] os_cnt;
    uamr_pkg::uamr_tx_state_t tx_state;
    logic [3:0] tx_ph;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    logic tx_line;
    uamr_pkg::uamr_rx_state_t rx_state;
    logic [3:0] rx_ph;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_par;
    logic txd;
    logic tx_ready;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_perr;
    logic rx_ferr;
    logic rts_n;
    logic dtr_n;
    uamr_pkg::uamr_modem_st_t modem_st;
    logic rst_out;
  } uamr_state_t;

  uamr_state_t st;
  uamr_state_t next_st;
  logic tick;
  logic rx_line;

  always_comb begin
    next_st = st;
    tick = (st.os_cnt == OS_DIV - 16'h0001);
    // loopback feeds the internal line back, the pin itself stays quiet
    rx_line = st.cfg.loopback ? st.tx_line : rxd;
    if (cfg_wr) begin
      next_st.cfg = cfg_in;
    end
    next_st.os_cnt = tick ? 16'h0000 : st.os_cnt + 16'h0001;
    next_st.rx_valid = 1'b0;
    case (st.tx_state)
      uamr_pkg::UAMR_TX_IDLE: begin
        next_st.tx_line = 1'b1;
        if (tx_valid && st.tx_ready) begin
          next_st.tx_sh = tx_data;
          next_st.tx_par = (^tx_data) ^ ~st.cfg.parity_even;
          next_st.tx_state = uamr_pkg::UAMR_TX_START;
          next_st.tx_ph = 4'h0;
          next_st.tx_line = 1'b0;
        end
      end
      uamr_pkg::UAMR_TX_START: begin
        if (tick) begin
          next_st.tx_ph = st.tx_ph + 4'h1;
          if (st.tx_ph == uamr_pkg::UAMR_PH_LAST) begin
            next_st.tx_state = uamr_pkg::UAMR_TX_DATA;
            next_st.tx_bit = 3'h0;
            next_st.tx_line = st.tx_sh[0];
          end
        end
      end
      uamr_pkg::UAMR_TX_DATA: begin
        if (tick) begin
          next_st.tx_ph = st.tx_ph + 4'h1;
          if (st.tx_ph == uamr_pkg::UAMR_PH_LAST) begin
            next_st.tx_sh = st.tx_sh >> 1;
            next_st.tx_line = st.tx_sh[1];
            next_st.tx_bit = st.tx_bit + 3'h1;
            if (st.tx_bit == uamr_pkg::UAMR_BIT_LAST) begin
              if (st.cfg.parity_en) begin
                next_st.tx_state = uamr_pkg::UAMR_TX_PAR;
                next_st.tx_line = st.tx_par;
              end else begin
                next_st.tx_state = uamr_pkg::UAMR_TX_STOP;
                next_st.tx_line = 1'b1;
                next_st.tx_bit = 3'h0;
              end
            end
          end
        end
      end
      uamr_pkg::UAMR_TX_PAR: begin
        if (tick) begin
          next_st.tx_ph = st.tx_ph + 4'h1;
          if (st.tx_ph == uamr_pkg::UAMR_PH_LAST) begin
            next_st.tx_state = uamr_pkg::UAMR_TX_STOP;
            next_st.tx_line = 1'b1;
            next_st.tx_bit = 3'h0;
          end
        end
      end
      uamr_pkg::UAMR_TX_STOP: begin
        if (tick) begin
          next_st.tx_ph = st.tx_ph + 4'h1;
          if (st.tx_ph == uamr_pkg::UAMR_PH_LAST) begin
            if (st.cfg.two_stop && st.tx_bit == 3'h0) begin
              next_st.tx_bit = 3'h1;
            end else begin
              next_st.tx_state = uamr_pkg::UAMR_TX_IDLE;
            end
          end
        end
      end
      default: next_st.tx_state = uamr_pkg::UAMR_TX_IDLE;
    endcase
    // receiver: hunt a low line level, recheck mid start bit, then sample mid bit
    case (st.rx_state)
      uamr_pkg::UAMR_RX_IDLE: begin
        if (!rx_line) begin
          next_st.rx_state = uamr_pkg::UAMR_RX_START;
          next_st.rx_ph = 4'h0;
        end
      end
      uamr_pkg::UAMR_RX_START: begin
        if (tick) begin
          next_st.rx_ph = st.rx_ph + 4'h1;
          if (st.rx_ph == uamr_pkg::UAMR_PH_MID) begin
            // a glitch shorter than half a bit is dropped, not framed
            next_st.rx_state = rx_line ? uamr_pkg::UAMR_RX_IDLE : uamr_pkg::UAMR_RX_DATA;
            next_st.rx_ph = 4'h0;
            next_st.rx_bit = 3'h0;
          end
        end
      end
      uamr_pkg::UAMR_RX_DATA: begin
        if (tick) begin
          next_st.rx_ph = st.rx_ph + 4'h1;
          if (st.rx_ph == uamr_pkg::UAMR_PH_LAST) begin
            next_st.rx_sh = {rx_line, st.rx_sh[7:1]};
            next_st.rx_bit = st.rx_bit + 3'h1;
            if (st.rx_bit == uamr_pkg::UAMR_BIT_LAST) begin
              next_st.rx_state = st.cfg.parity_en ? uamr_pkg::UAMR_RX_PAR : uamr_pkg::UAMR_RX_STOP;
            end
          end
        end
      end
      uamr_pkg::UAMR_RX_PAR: begin
        if (tick) begin
          next_st.rx_ph = st.rx_ph + 4'h1;
          if (st.rx_ph == uamr_pkg::UAMR_PH_LAST) begin
            next_st.rx_par = rx_line;
            next_st.rx_state = uamr_pkg::UAMR_RX_STOP;
          end
        end
      end
      uamr_pkg::UAMR_RX_STOP: begin
        if (tick) begin
          next_st.rx_ph = st.rx_ph + 4'h1;
          if (st.rx_ph == uamr_pkg::UAMR_PH_LAST) begin
            next_st.rx_valid = 1'b1;
            next_st.rx_data = st.rx_sh;
            next_st.rx_ferr = !rx_line;
            next_st.rx_perr = st.cfg.parity_en && (st.rx_par != ((^st.rx_sh) ^ ~st.cfg.parity_even));
            next_st.rx_state = uamr_pkg::UAMR_RX_IDLE;
          end
        end
      end
      default: next_st.rx_state = uamr_pkg::UAMR_RX_IDLE;
    endcase
    next_st.tx_ready = (next_st.tx_state == uamr_pkg::UAMR_TX_IDLE) && next_st.cfg.tx_en;
    next_st.txd = (next_st.cfg.loopback || !next_st.cfg.tx_en) ? 1'b1 : next_st.tx_line;
    next_st.rts_n = ~next_st.cfg.rts;
    next_st.dtr_n = ~next_st.cfg.dtr;
    next_st.modem_st = ~modem_in;
    // reset input high forces the output through the async branch below
    next_st.rst_out = next_st.cfg.soft_rst_en & next_st.cfg.soft_rst;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.cfg <= uamr_pkg::UAMR_CFG_RST;
      st.tx_line <= 1'b1;
      st.txd <= 1'b1;
      st.rts_n <= 1'b1;
      st.dtr_n <= 1'b1;
      st.rst_out <= 1'b1;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign tx_ready = st.tx_ready;
  assign rx_valid = st.rx_valid;
  assign rx_data = st.rx_data;
  assign rx_perr = st.rx_perr;
  assign rx_ferr = st.rx_ferr;
  assign txd = st.txd;
  assign rts_n = st.rts_n;
  assign dtr_n = st.dtr_n;
  assign modem_st = st.modem_st;
  assign rst_out = st.rst_out;

  // the first edge may come before the async load has landed, so check from the second reset edge on
  chk_cfg_reset_default: assert property (@(posedge clk)
    rst ##1 rst |-> st.cfg == uamr_pkg::UAMR_CFG_RST && rst_out && txd)
    else $error("config or outputs not at default during reset");
  chk_rst_mirror_input: assert property (@(posedge clk) disable iff (rst)
    ce && !next_st.cfg.soft_rst_en |=> !rst_out)
    else $error("reset output not following reset input");
  chk_rst_soft_or: assert property (@(posedge clk) disable iff (rst)
    ce && cfg_wr && cfg_in.soft_rst_en && cfg_in.soft_rst |=> rst_out)
    else $error("soft reset did not raise reset output");
  chk_rst_soft_clear: assert property (@(posedge clk) disable iff (rst)
    ce && cfg_wr && !cfg_in.soft_rst |=> !rst_out)
    else $error("cleared soft reset left reset output high");
  chk_rts_active_low: assert property (@(posedge clk) disable iff (rst)
    ce && cfg_wr |=> rts_n == !$past(cfg_in.rts) && dtr_n == !$past(cfg_in.dtr))
    else $error("rts or dtr not active low");
  chk_modem_in_low: assert property (@(posedge clk) disable iff (rst)
    ce |=> modem_st == ~$past(modem_in))
    else $error("modem input decode wrong");
  chk_tx_start_low: assert property (@(posedge clk) disable iff (rst)
    ce && tx_valid && tx_ready && !st.cfg.loopback && !cfg_wr |=> !txd ##0 st.tx_state == uamr_pkg::UAMR_TX_START)
    else $error("start bit not driven low");
  chk_tx_stop_high: assert property (@(posedge clk) disable iff (rst)
    st.tx_state == uamr_pkg::UAMR_TX_STOP |-> txd && st.tx_line)
    else $error("stop bit not high");
  chk_tx_idle_loop: assert property (@(posedge clk) disable iff (rst)
    st.tx_state == uamr_pkg::UAMR_TX_IDLE || st.cfg.loopback || !st.cfg.tx_en |-> txd)
    else $error("serial output low while idle or disabled");
  chk_rx_no_parity: assert property (@(posedge clk) disable iff (rst)
    rx_valid && !st.cfg.parity_en |-> !rx_perr)
    else $error("parity error flagged with parity off");
  chk_rx_glitch_drop: assert property (@(posedge clk) disable iff (rst)
    st.rx_state == uamr_pkg::UAMR_RX_START && tick && ce && st.rx_ph == uamr_pkg::UAMR_PH_MID && rx_line
    |=> st.rx_state == uamr_pkg::UAMR_RX_IDLE)
    else $error("false start bit not rejected");

  cov_tx_char: cover property (@(posedge clk) disable iff (rst) ce && tx_valid && tx_ready);
  cov_rx_char: cover property (@(posedge clk) disable iff (rst) rx_valid && !rx_perr && !rx_ferr);
  cov_rx_perr: cover property (@(posedge clk) disable iff (rst) rx_valid && rx_perr);
  cov_soft_rst: cover property (@(posedge clk) disable iff (rst) $rose(rst_out));

endmodule : uamr_top
`default_nettype wire

// ### verif/uamr_peer.sv
// serial peer model: drives rxd and the modem pins, captures frames from txd
`default_nettype none
module uamr_peer #(
  parameter int BIT_CYC = 32
) (
  input wire logic clk,
  input wire logic txd,
  output logic rxd,
  output uamr_pkg::uamr_modem_in_t modem_in
);
  initial begin
    rxd = 1'b1;  // idle line level
    modem_in = 4'hf;
  end

  task automatic set_modem(input logic [3:0] v);
    @(negedge clk);
    modem_in = v;
  endtask : set_modem

  // start, data lsb first, optional parity, stop level sb; ends on the idle level
  task automatic send(input logic [7:0] d, input logic pe, input logic pb, input logic sb);
    logic [10:0] fr;
    int n;
    fr = {sb, pe ? pb : sb, d, 1'b0};
    n = pe ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      rxd = fr[i];
      repeat (BIT_CYC / 2 + 3) @(negedge clk);
      // a low stop bit is cut short past mid-bit, so its tail is only a glitch to the receiver
      if (i == n - 1) rxd = 1'b1;
      repeat (BIT_CYC / 2 - 4) @(negedge clk);
    end
  endtask : send

  // samples mid-bit; tolerates a start bit shortened by one tick of phase
  task automatic capture(output logic [9:0] b, output logic ok);
    int t;
    t = 0;
    while (txd !== 1'b0 && t < 4 * BIT_CYC) begin
      @(negedge clk);
      t++;
    end
    ok = (txd === 1'b0);
    repeat (BIT_CYC / 2) @(negedge clk);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CYC) @(negedge clk);
      b[i] = txd;
    end
  endtask : capture
endmodule : uamr_peer
`default_nettype wire

// ### verif/tb_top.sv
// testbench: reset path, modem pins, framing, parity and loopback
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ce, cfg_wr, tx_valid, tx_ready, rx_valid, rx_perr, rx_ferr, rxd, txd, rts_n, dtr_n, rst_out;
  logic [7:0] tx_data, rx_data;
  uamr_pkg::uamr_cfg_t cfg_in, c;
  uamr_pkg::uamr_modem_in_t modem_in;
  uamr_pkg::uamr_modem_st_t modem_st;
  logic [15:0] seed;
  logic [9:0] bits;
  logic ok, pe, pv, bad;
  int n_errors, checks, lows;

  uamr_top #(.OS_DIV(16'h0002)) u_dut (.clk(clk), .rst(rst), .ce(ce), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_perr(rx_perr), .rx_ferr(rx_ferr), .rxd(rxd), .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n),
    .modem_in(modem_in), .modem_st(modem_st), .rst_out(rst_out));
  uamr_peer #(.BIT_CYC(32)) u_peer (.clk(clk), .txd(txd), .rxd(rxd), .modem_in(modem_in));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic par_of(input logic [7:0] d, input logic even);
    return even ? ^d : ~^d;
  endfunction : par_of

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_byte

  // rst_out is registered, so two settled cycles are allowed
  task automatic wr_cfg(input uamr_pkg::uamr_cfg_t v);
    @(negedge clk);
    cfg_in = v;
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
    repeat (2) @(negedge clk);
  endtask : wr_cfg

  task automatic wait_rx(output logic got);
    got = 1'b0;
    lows = 0;
    for (int t = 0; t < 900 && !got; t++) begin
      @(negedge clk);
      if (txd !== 1'b1) lows++;
      got = (rx_valid === 1'b1);
    end
  endtask : wait_rx

  task automatic print_verdict();
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    print_verdict();
  end

  initial begin
    rst = 1'b1; ce = 1'b1; cfg_wr = 1'b0; cfg_in = '0; tx_valid = 1'b0; tx_data = 8'h00;
    seed = 16'hf9f6;
    repeat (8) @(negedge clk);
    cmp_bit(txd, 1'b1);
    cmp_bit(rst_out, 1'b1);
    cmp_bit(rts_n & dtr_n, 1'b1);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    cmp_bit(rst_out, 1'b0);
    for (int i = 0; i < 16; i++) begin
      c = '0; c.soft_rst_en = i[0]; c.soft_rst = i[1]; c.rts = i[2]; c.dtr = i[3]; c.tx_en = i[2];
      wr_cfg(c);
      cmp_bit(rst_out, i[0] & i[1]);
      cmp_bit(rts_n, ~i[2]);
      cmp_bit(dtr_n, ~i[3]);
      cmp_bit(tx_ready, i[2]);
      cmp_bit(txd, 1'b1);
    end
    c = '0; c.soft_rst = 1'b1; c.rts = 1'b1;
    wr_cfg(c);
    cmp_bit(rst_out, 1'b0);
    // second reset in mid-run must restore defaults and raise the output
    @(negedge clk) rst = 1'b1;
    repeat (2) @(negedge clk);
    cmp_bit(rst_out, 1'b1);
    cmp_bit(rts_n, 1'b1);
    rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      u_peer.set_modem(seed[3:0]);
      @(negedge clk);
      cmp_byte({4'h0, modem_st}, {4'h0, ~seed[3:0]});
    end
    // ce low must freeze the pin decode as well
    ce = 1'b0;
    u_peer.set_modem(~seed[3:0]);
    repeat (2) @(negedge clk);
    cmp_byte({4'h0, modem_st}, {4'h0, ~seed[3:0]});
    ce = 1'b1;
    @(negedge clk);
    cmp_byte({4'h0, modem_st}, {4'h0, seed[3:0]});
    u_peer.set_modem(4'hf);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      // the corrupted-parity case needs parity switched on to be seen at all
      pe = seed[8] | (i < 2) | (i == 6);
      pv = seed[9];
      bad = (i == 6);
      c = '0; c.tx_en = 1'b1; c.parity_en = pe; c.parity_even = pv; c.two_stop = seed[10];
      wr_cfg(c);
      if (i < 6) begin
        for (int t = 0; t < 900 && tx_ready !== 1'b1; t++) @(negedge clk);
        tx_valid = 1'b1;
        tx_data = seed[7:0];
        @(negedge clk) tx_valid = 1'b0;
        u_peer.capture(bits, ok);
        cmp_bit(ok, 1'b1);
        cmp_byte(bits[7:0], seed[7:0]);
        cmp_bit(bits[8], pe ? par_of(seed[7:0], pv) : 1'b1);
        cmp_bit(bits[9], 1'b1);
      end else begin
        fork
          u_peer.send(seed[7:0], pe, par_of(seed[7:0], pv) ^ bad, i != 9);
          wait_rx(ok);
        join
        cmp_bit(ok, 1'b1);
        cmp_byte(rx_data, seed[7:0]);
        cmp_bit(rx_perr, bad);
        cmp_bit(rx_ferr, i == 9);
      end
    end
    // loopback: pin stays high while the character returns internally
    c = '0; c.tx_en = 1'b1; c.loopback = 1'b1; c.parity_en = 1'b1; c.parity_even = 1'b1;
    wr_cfg(c);
    tx_valid = 1'b1;
    tx_data = 8'ha5;
    @(negedge clk) tx_valid = 1'b0;
    wait_rx(ok);
    cmp_bit(ok, 1'b1);
    cmp_byte(rx_data, 8'ha5);
    cmp_bit(lows == 0, 1'b1);
    cmp_bit(rx_perr, 1'b0);
    cmp_bit(rx_ferr, 1'b0);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
